// ==== hdl/adc_readout_regs.vh ====
`ifndef ADC_READOUT_REGS_VH
`define ADC_READOUT_REGS_VH

// Word layouts
`define NOLAT_DIFF_BITS     14
`define NOLAT_CM_BITS       8
`define NOLAT_WORD_BITS     22
`define FILT_CODE_BITS      24
`define FILT_CFG_BITS       8
`define FILT_WORD_BITS      32

// Bit counter width, enough for 32 plus overrun
`define SHIFT_CNT_BITS      6

// Configuration words per decimation factor select
`define DEC_SEL_4           2'h0
`define DEC_SEL_8           2'h1
`define DEC_SEL_16          2'h2
`define DEC_SEL_32          2'h3
`define CFG_WORD_DF4        8'h26
`define CFG_WORD_DF8        8'h36
`define CFG_WORD_DF16       8'h46
`define CFG_WORD_DF32       8'h56

// Pin synchroniser bit positions
`define PIN_BUSY            5
`define PIN_READY           4
`define PIN_NOLAT_EN        3
`define PIN_NOLAT_SCK       2
`define PIN_FILT_EN         1
`define PIN_FILT_SCK        0

// Idle pin levels: enables high, strobes and serial clocks low
`define PIN_IDLE_LEVELS     6'h0A

`endif

// ==== hdl/serial_shift_out.v ====
`timescale 1ns/100ps
`include "adc_readout_regs.vh"

// One read-only serial output: loads a snapshot, shifts on serial clock fall
module serial_shift_out #(
    parameter WIDTH = 32
) (
    input  wire             ref_clk,
    input  wire             rst_sync_b,
    input  wire             load_pulse,
    input  wire [WIDTH-1:0] load_word,
    input  wire             shift_pulse,
    input  wire             enable,
    output reg              data_out,
    output reg              data_oe_b
);

    // --------------------------------------------------------------
    // Shift state
    // --------------------------------------------------------------
    reg [WIDTH-1:0] shift_reg;

    // Load wins over shift; zeros fill in from the bottom past word end
    always @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            shift_reg <= {WIDTH{1'b0}};
            data_out  <= 1'b0;
            data_oe_b <= 1'b1;
        end else begin
            if (load_pulse) begin
                shift_reg <= load_word;
                data_out  <= load_word[WIDTH-1];
            end else if (shift_pulse && enable) begin
                shift_reg <= {shift_reg[WIDTH-2:0], 1'b0};
                data_out  <= shift_reg[WIDTH-2];
            end
            data_oe_b <= ~enable;
        end
    end

endmodule

// ==== hdl/adc_dual_serial_readout.v ====
//Behaviour
//- Read-enable tied low keeps no-latency output on; top bit after busy falls.
//- No-latency read-enable fall places its top bit on the data line.
//- Filtered read-enable fall places filtered top bit on the line.
//- No-latency read-enable fall places its top bit on joined line.
//- No-latency word is 14-bit differential then 8-bit common mode, MSB first.
//- Filtered word is 24-bit code then 8-bit configuration word.
//- Filtered enable held low; top bit follows ready strobe falling.
`timescale 1ns/100ps
`include "adc_readout_regs.vh"

module adc_dual_serial_readout (
    ref_clk,
    rst_b,
    conv_busy,
    filtered_ready_strobe,
    nolat_diff_code,
    nolat_cm_code,
    filt_code,
    decimation_factor,
    nolat_read_en_n,
    nolat_serial_clk,
    filt_read_en_n,
    filt_serial_clk,
    nolat_serial_out,
    nolat_serial_oe_b,
    filt_serial_out,
    filt_serial_oe_b
);

    input  wire                          ref_clk;
    input  wire                          rst_b;
    input  wire                          conv_busy;
    input  wire                          filtered_ready_strobe;
    input  wire [`NOLAT_DIFF_BITS-1:0]   nolat_diff_code;
    input  wire [`NOLAT_CM_BITS-1:0]     nolat_cm_code;
    input  wire [`FILT_CODE_BITS-1:0]    filt_code;
    input  wire [1:0]                    decimation_factor;
    input  wire                          nolat_read_en_n;
    input  wire                          nolat_serial_clk;
    input  wire                          filt_read_en_n;
    input  wire                          filt_serial_clk;
    output wire                          nolat_serial_out;
    output wire                          nolat_serial_oe_b;
    output wire                          filt_serial_out;
    output wire                          filt_serial_oe_b;

    // --------------------------------------------------------------
    // Functions
    // --------------------------------------------------------------
    // Decimation select to trailing configuration word
    function [`FILT_CFG_BITS-1:0] cfg_word;
        input [1:0] sel;
        begin
            case (sel)
                `DEC_SEL_4:  cfg_word = `CFG_WORD_DF4;
                `DEC_SEL_8:  cfg_word = `CFG_WORD_DF8;
                `DEC_SEL_16: cfg_word = `CFG_WORD_DF16;
                default:     cfg_word = `CFG_WORD_DF32;
            endcase
        end
    endfunction

    // One-cycle fall flag from previous and current synchronised level
    function fell_edge;
        input prev_level;
        input now_level;
        begin
            fell_edge = prev_level & ~now_level;
        end
    endfunction

    // No-latency word: differential code above common-mode code
    function [`NOLAT_WORD_BITS-1:0] nolat_pack;
        input [`NOLAT_DIFF_BITS-1:0] diff;
        input [`NOLAT_CM_BITS-1:0]   cm;
        begin
            nolat_pack = {diff, cm};
        end
    endfunction

    // Filtered word: code above the decimation configuration word
    function [`FILT_WORD_BITS-1:0] filt_pack;
        input [`FILT_CODE_BITS-1:0] code;
        input [1:0]                 sel;
        begin
            filt_pack = {code, cfg_word(sel)};
        end
    endfunction

    // --------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;

    // Asynchronous assert, two-flop release
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    // Bits: busy, ready, nolat en, nolat clk, filt en, filt clk
    reg [5:0] pin_meta_reg;
    reg [5:0] pin_sync_reg;
    reg [5:0] pin_prev_reg;

    // Enables reset high so no output drives before a real select
    always @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pin_meta_reg <= `PIN_IDLE_LEVELS;
            pin_sync_reg <= `PIN_IDLE_LEVELS;
            pin_prev_reg <= `PIN_IDLE_LEVELS;
        end else begin
            pin_meta_reg <= {conv_busy, filtered_ready_strobe, nolat_read_en_n,
                             nolat_serial_clk, filt_read_en_n, filt_serial_clk};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // --------------------------------------------------------------
    // Edge detection
    // --------------------------------------------------------------
    // Fall pulses one ref_clk wide and active-high enable levels, two edges behind the pins
    wire busy_fall      = fell_edge(pin_prev_reg[`PIN_BUSY], pin_sync_reg[`PIN_BUSY]);
    wire ready_fall     = fell_edge(pin_prev_reg[`PIN_READY], pin_sync_reg[`PIN_READY]);
    wire nolat_en       = ~pin_sync_reg[`PIN_NOLAT_EN];
    wire nolat_en_fall  = fell_edge(pin_prev_reg[`PIN_NOLAT_EN], pin_sync_reg[`PIN_NOLAT_EN]);
    wire nolat_sck_fall = fell_edge(pin_prev_reg[`PIN_NOLAT_SCK], pin_sync_reg[`PIN_NOLAT_SCK]);
    wire filt_en        = ~pin_sync_reg[`PIN_FILT_EN];
    wire filt_en_fall   = fell_edge(pin_prev_reg[`PIN_FILT_EN], pin_sync_reg[`PIN_FILT_EN]);
    wire filt_sck_fall  = fell_edge(pin_prev_reg[`PIN_FILT_SCK], pin_sync_reg[`PIN_FILT_SCK]);

    // --------------------------------------------------------------
    // Result snapshots
    // --------------------------------------------------------------
    // Results are taken at the strobe falls so they stay still during a read
    reg [`NOLAT_WORD_BITS-1:0] nolat_word_reg;
    reg [`FILT_WORD_BITS-1:0]  filt_word_reg;

    // No-latency snapshot, taken when conversion busy falls
    always @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            nolat_word_reg <= {`NOLAT_WORD_BITS{1'b0}};
        end else if (busy_fall) begin
            nolat_word_reg <= nolat_pack(nolat_diff_code, nolat_cm_code);
        end
    end

    // Filtered snapshot, taken when the ready strobe falls
    always @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            filt_word_reg <= {`FILT_WORD_BITS{1'b0}};
        end else if (ready_fall) begin
            filt_word_reg <= filt_pack(filt_code, decimation_factor);
        end
    end

    // --------------------------------------------------------------
    // Load control
    // --------------------------------------------------------------
    // Load when busy (no-latency) or ready (filtered) falls with enable held low, or on enable fall
    wire nolat_load = (busy_fall & nolat_en) | nolat_en_fall;
    wire filt_load  = (ready_fall & filt_en) | filt_en_fall;

    reg [`NOLAT_WORD_BITS-1:0] nolat_load_word;
    reg [`FILT_WORD_BITS-1:0]  filt_load_word;

    // Same-cycle capture bypasses the snapshot, saving a cycle of latency
    always @* begin
        if (busy_fall)
            nolat_load_word = nolat_pack(nolat_diff_code, nolat_cm_code);
        else
            nolat_load_word = nolat_word_reg;
        if (ready_fall)
            filt_load_word = filt_pack(filt_code, decimation_factor);
        else
            filt_load_word = filt_word_reg;
    end

    // --------------------------------------------------------------
    // Serial outputs
    // --------------------------------------------------------------
    serial_shift_out #(
        .WIDTH (`NOLAT_WORD_BITS)
    ) nolat_shifter (
        .ref_clk     (ref_clk),
        .rst_sync_b  (rst_sync_reg),
        .load_pulse  (nolat_load),
        .load_word   (nolat_load_word),
        .shift_pulse (nolat_sck_fall),
        .enable      (nolat_en),
        .data_out    (nolat_serial_out),
        .data_oe_b   (nolat_serial_oe_b)
    );

    serial_shift_out #(
        .WIDTH (`FILT_WORD_BITS)
    ) filt_shifter (
        .ref_clk     (ref_clk),
        .rst_sync_b  (rst_sync_reg),
        .load_pulse  (filt_load),
        .load_word   (filt_load_word),
        .shift_pulse (filt_sck_fall),
        .enable      (filt_en),
        .data_out    (filt_serial_out),
        .data_oe_b   (filt_serial_oe_b)
    );

endmodule

// ==== test/readout_checker_asserts.sv ====
`timescale 1ns/100ps
module readout_checker (
    input wire        ref_clk,
    input wire        rst_b,
    input wire        nolat_read_en_n,
    input wire        filt_read_en_n,
    input wire [13:0] nolat_diff_code,
    input wire [23:0] filt_code,
    input wire        nolat_serial_out,
    input wire        nolat_serial_oe_b,
    input wire        filt_serial_out,
    input wire        filt_serial_oe_b
);
    // Enable pins reach the outputs three to four edges late
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    nolat_idle_hiz_a: assert property (nolat_read_en_n [*5] |-> nolat_serial_oe_b)
        else $error("nolat out driven while disabled");
    filt_idle_hiz_a: assert property (filt_read_en_n [*5] |-> filt_serial_oe_b)
        else $error("filt out driven while disabled");
    nolat_drives_a: assert property (!nolat_read_en_n [*5] |-> !nolat_serial_oe_b)
        else $error("nolat out not driven");
    filt_drives_a: assert property (!filt_read_en_n [*5] |-> !filt_serial_oe_b)
        else $error("filt out not driven");
    nolat_top_a: assert property ($fell(nolat_read_en_n) |-> ##5 nolat_serial_out == nolat_diff_code[13])
        else $error("nolat top bit wrong");
    filt_top_a: assert property ($fell(filt_read_en_n) |-> ##5 filt_serial_out == filt_code[23])
        else $error("filt top bit wrong");
    nolat_oe_cause_a: assert property ($fell(nolat_serial_oe_b) |-> !$past(nolat_read_en_n, 2))
        else $error("nolat drive without enable");
    filt_oe_cause_a: assert property ($fell(filt_serial_oe_b) |-> !$past(filt_read_en_n, 2))
        else $error("filt drive without enable");
endmodule
bind adc_dual_serial_readout readout_checker chk (.ref_clk, .rst_b, .nolat_read_en_n, .filt_read_en_n,
    .nolat_diff_code, .filt_code, .nolat_serial_out, .nolat_serial_oe_b, .filt_serial_out, .filt_serial_oe_b);

// ==== test/serial_host_model.sv ====
`timescale 1ns/100ps
module serial_host_model (
    output reg  sck,
    output reg  ren_a_n,
    output reg  ren_b_n,
    input  wire sdo
);
    // Idle with both enables high and the clock still
    initial begin
        sck = 1'b0;
        ren_a_n = 1'b1;
        ren_b_n = 1'b1;
    end
    // Shared clock and line serve both outputs; sample late in the low half
    task read(input bit sel, input int n, output logic [32:0] w);
        begin
            if (sel) ren_a_n = 1'b0; else ren_b_n = 1'b0;
            #400;
            w = 33'h0;
            for (int i = 0; i < n; i++) begin
                w = {w[31:0], sdo};
                sck = 1'b1;
                #150;
                sck = 1'b0;
                #250;
            end
            ren_a_n = 1'b1;
            ren_b_n = 1'b1;
            #200;
        end
    endtask
endmodule

// ==== test/adc_dual_serial_readout_tb_top.sv ====
`timescale 1ns/100ps
module adc_dual_serial_readout_tb_top;
    reg          ref_clk, rst_b, conv_busy, rdy, last;
    reg  [13:0]  diff;
    reg  [7:0]   cm, cfg;
    reg  [23:0]  fc;
    reg  [1:0]   dsel;
    reg  [32:0]  w;
    wire         nren, fren, sck, nout, noe, fout, foe;
    int          miscompares = 0, num_checks = 0;
    // Rows: diff, common mode, filtered code, factor select, expected config word
    reg  [55:0]  rows [4] = '{{14'h2A5C, 8'hC3, 24'h9ABCDE, 2'h0, 8'h26}, {14'h1234, 8'h5A, 24'h123456, 2'h1, 8'h36},
                              {14'h3FFF, 8'h00, 24'hFFFFFF, 2'h2, 8'h46}, {14'h0001, 8'h81, 24'h000001, 2'h3, 8'h56}};
    // Released line shows the inverse of its last level, no pull
    wire         line = !noe ? nout : !foe ? fout : ~last;
    always @(posedge ref_clk) if (!noe || !foe) last <= line;
    serial_host_model host (.sck(sck), .ren_a_n(fren), .ren_b_n(nren), .sdo(line));
    adc_dual_serial_readout uut (.ref_clk(ref_clk), .rst_b(rst_b), .conv_busy(conv_busy),
        .filtered_ready_strobe(rdy), .nolat_diff_code(diff), .nolat_cm_code(cm), .filt_code(fc),
        .decimation_factor(dsel), .nolat_read_en_n(nren), .nolat_serial_clk(sck), .filt_read_en_n(fren),
        .filt_serial_clk(sck), .nolat_serial_out(nout), .nolat_serial_oe_b(noe), .filt_serial_out(fout),
        .filt_serial_oe_b(foe));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task check(input logic [32:0] got, input logic [32:0] exp);
        begin
            num_checks++;
            if (got !== exp) begin
                miscompares++;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Busy and ready strobe pulse together, high then low for eight cycles each
    task pulse;
        begin
            conv_busy = 1'b1;
            rdy = 1'b1;
            repeat (8) @(negedge ref_clk);
            conv_busy = 1'b0;
            rdy = 1'b0;
            repeat (8) @(negedge ref_clk);
        end
    endtask
    task report_and_stop;
        begin
            $display("Checks %0d, mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        {rst_b, conv_busy, rdy, last, diff, cm, fc, dsel} = 0;
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge ref_clk);
        check({noe, foe}, 2'b11);
        for (int r = 0; r < 4; r++) begin
            {diff, cm, fc, dsel, cfg} = rows[r];
            pulse;
            host.read(0, 24, w);
            check(w, {9'h0, diff, cm, 2'b00});
            host.read(1, 33, w);
            check(w, {fc, cfg, 1'b0});
        end
        // Abandoned read then a fresh one must restart at the top
        host.read(0, 5, w);
        host.read(0, 24, w);
        check(w, {9'h0, diff, cm, 2'b00});
        // Enables held low across a new result
        host.ren_a_n = 1'b0;
        host.ren_b_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        diff = 14'h3000;
        fc = 24'h800000;
        pulse;
        check({noe, nout, foe, fout}, 4'b0101);
        host.ren_a_n = 1'b1;
        host.ren_b_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        check({noe, foe}, 2'b11);
        // Reset in mid-run releases a driving output and clears both results
        host.ren_b_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        check({noe, nout}, 2'b01);
        diff = 14'h0000;
        fc = 24'h000000;
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        check({noe, nout, foe, fout}, 4'b1010);
        host.ren_b_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge ref_clk);
        check({noe, foe}, 2'b11);
        host.read(0, 24, w);
        check(w, 33'h0);
        host.read(1, 33, w);
        check(w, 33'h0);
        report_and_stop;
    end
endmodule
